// ---- src/pbus_regs.svh ----
// Timing and address constants of the parallel peripheral bus master.
// Assumes a single processor clock; all counts derive from its period.
`ifndef PBUS_REGS_SVH
`define PBUS_REGS_SVH

// Processor clock period, in picoseconds.
`define CLK_PERIOD_PS 100000

// Address and select setup before a strobe falls.
`define ADDR_SETUP_PS 325
// Data hold after the write strobe rises.
`define DATA_HOLD_PS 2325
// Longest time the converter keeps driving the bus after a read.
`define BUS_RELEASE_PS 40000

// Least times round up to whole cycles; none is below one cycle.
`define CEIL_CYC(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_CYCLES `CEIL_CYC(`ADDR_SETUP_PS)
`define HOLD_CYCLES `CEIL_CYC(`DATA_HOLD_PS)
`define TURN_CYCLES `CEIL_CYC(`BUS_RELEASE_PS)

// Recommended wait states for the converter pair.
`define ADC_RECOMMENDED_WS 4'h5
`define DAC_RECOMMENDED_WS 4'h2

// Default peripheral addresses on the external address bus.
`define ADC_DEFAULT_ADDR 14'h0000
`define DAC_DEFAULT_ADDR 14'h0001

`endif

// ---- src/pbus_pkg.sv ----
// Types shared by the parallel peripheral bus master and its FIFO.
// Assumes a 14-bit external address bus and a 16-bit data bus.
package pbus_pkg;

	typedef logic [13:0] addr_t;
	typedef logic [15:0] word_t;
	typedef logic [3:0] ws_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SETUP = 5'h02,
		ST_STROBE = 5'h04,
		ST_HOLD = 5'h08,
		ST_TURN = 5'h10
	} bus_state_e;

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_CTRL = 2'h1,
		OP_DAC = 2'h2
	} bus_op_e;

endpackage : pbus_pkg

// ---- src/stream_if.sv ----
// Valid/ready word stream between the bus master and its FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface stream_if #(parameter int WIDTH = 16) ();
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport snk (input valid, input data, output ready);
	modport src (output valid, output data, input ready);
endinterface : stream_if

// ---- src/word_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; storage is flip-flops indexed by wrapping pointers.
`timescale 1ns/1ns
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Filling and draining sides
	stream_if.snk in_s,
	stream_if.src out_s
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;

	wire push = in_s.valid && in_s.ready;
	wire pop = out_s.valid && out_s.ready;
	wire wr_last = (wr_ptr_q == AW'(DEPTH - 1));
	wire rd_last = (rd_ptr_q == AW'(DEPTH - 1));

	assign in_s.ready = (count_q != (AW+1)'(DEPTH));
	assign out_s.valid = (count_q != '0);
	assign out_s.data = mem_q[rd_ptr_q];

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_s.data;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_last ? '0 : wr_ptr_q + AW'(1);
			if (pop)
				rd_ptr_q <= rd_last ? '0 : rd_ptr_q + AW'(1);
			if (push && !pop)
				count_q <= count_q + (AW+1)'(1);
			else if (pop && !push)
				count_q <= count_q - (AW+1)'(1);
		end
	end
endmodule : word_fifo

// ---- src/pbus_master.sv ----
// Processor-side master of a parallel bus to a memory-mapped ADC and DAC.
// Assumes external decode logic makes the converter chip selects from
// the space selects and the address, and that the data bus wire is
// resolved outside from data_out and data_oe.
//
// Functional notes
// RULE1 - A DAC request on its interrupt line starts a write cycle.
// RULE2 - Address and space select assert together; DAC writes use data space.
// RULE3 - Outside decode logic makes the chip select from select and address.
// RULE4 - Write strobe falls after select; data is valid before it rises.
// RULE5 - The peripheral captures the data bus on the rising write strobe.
// RULE6 - Timing is in whole clocks; each wait state adds one strobe period.
// RULE7 - Accesses to the ADC use five wait states for its memory space.
// RULE8 - Accesses to the DAC use two wait states for its memory space.
// RULE9 - The DAC input latch passes to its output latch on the sample strobe.
// RULE10 - The DAC output-latch strobe also asks for the next word.
// RULE11 - ADC busy falling marks a finished conversion and requests a read.
// RULE12 - The ADC control register is writable; normal work is sample reads.
// RULE13 - No write follows an ADC read before the ADC releases the bus.
// RULE14 - Each memory space has its own wait-state count, zero to fifteen.
// RULE15 - Address, select and strobe hold steady during wait states.
// RULE16 - The read strobe enables the peripheral; data is taken as it rises. The code takes the synchronised bus word from two cycles before the rise.
// RULE17 - The data bus drivers are released outside write cycles.
`timescale 1ns/1ns
`include "pbus_regs.svh"
module pbus_master #(
	parameter pbus_pkg::addr_t ADC_ADDR = `ADC_DEFAULT_ADDR,
	parameter pbus_pkg::addr_t DAC_ADDR = `DAC_DEFAULT_ADDR,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// External bus pins
	output pbus_pkg::addr_t addr,
	output logic data_space_select_n,
	output logic io_space_select_n,
	output logic rd_n,
	output logic wr_n,
	output pbus_pkg::word_t data_out,
	output logic data_oe,
	input wire pbus_pkg::word_t data_in,
	// Converter request pins
	input wire logic dac_latch_irq_n,
	input wire logic adc_busy,
	// Wait-state configuration
	input wire logic use_recommended_ws,
	input wire pbus_pkg::ws_t io_wait_states,
	input wire pbus_pkg::ws_t data_wait_states,
	// DAC word stream from the processor core
	input wire logic dac_word_valid,
	input wire pbus_pkg::word_t dac_word_data,
	output logic dac_word_ready,
	// ADC control register writes
	input wire logic ctrl_valid,
	input wire pbus_pkg::word_t ctrl_data,
	output logic ctrl_ready,
	// ADC samples
	output logic sample_valid,
	output pbus_pkg::word_t sample_data,
	// Status
	output logic bus_busy
);
	import pbus_pkg::*;

	// Request pins and the data bus come from outside this clock domain.
	logic dac_irq_s1_q;
	logic dac_irq_s2_q;
	logic dac_irq_s3_q;
	logic adc_busy_s1_q;
	logic adc_busy_s2_q;
	logic adc_busy_s3_q;
	word_t din_s1_q;
	word_t din_s2_q;

	bus_state_e state_q;
	bus_state_e state_d;
	bus_op_e op_q;
	bus_op_e op_d;
	ws_t cnt_q;
	ws_t cnt_d;
	logic dac_pend_q;
	logic dac_pend_d;
	logic adc_pend_q;
	logic adc_pend_d;

	addr_t addr_q;
	word_t dout_q;
	logic dss_n_q;
	logic ioss_n_q;
	logic rd_n_q;
	logic wr_n_q;
	logic doe_q;
	word_t sample_data_q;
	logic sample_valid_q;

	stream_if #(.WIDTH($bits(word_t))) fifo_in ();
	stream_if #(.WIDTH($bits(word_t))) fifo_out ();

	// Words wait here so the core need not meet the DAC request instant.
	word_fifo #(
		.WIDTH($bits(word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_dac_fifo (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.in_s(fifo_in),
		.out_s(fifo_out)
	);

	assign fifo_in.valid = dac_word_valid;
	assign fifo_in.data = dac_word_data;
	assign dac_word_ready = fifo_in.ready;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dac_irq_s1_q <= 1'b1;
			dac_irq_s2_q <= 1'b1;
			dac_irq_s3_q <= 1'b1;
			adc_busy_s1_q <= 1'b0;
			adc_busy_s2_q <= 1'b0;
			adc_busy_s3_q <= 1'b0;
			din_s1_q <= '0;
			din_s2_q <= '0;
		end
		else
		begin
			dac_irq_s1_q <= dac_latch_irq_n;
			dac_irq_s2_q <= dac_irq_s1_q;
			dac_irq_s3_q <= dac_irq_s2_q;
			adc_busy_s1_q <= adc_busy;
			adc_busy_s2_q <= adc_busy_s1_q;
			adc_busy_s3_q <= adc_busy_s2_q;
			din_s1_q <= data_in;
			din_s2_q <= din_s1_q;
		end
	end

	// The DAC latch strobe going low asks for the next word.
	wire dac_request = !dac_irq_s2_q && dac_irq_s3_q; // [RULE1] [RULE10]
	// Busy falling means a conversion result is waiting.
	wire adc_done = !adc_busy_s2_q && adc_busy_s3_q; // [RULE11]

	// Arbitration: a finished conversion is served first, since a late
	// read loses the sample; control writes beat DAC refills.
	wire idle = (state_q == ST_IDLE);
	wire start_read = idle && adc_pend_q; // [RULE16]
	wire start_ctrl = idle && !adc_pend_q && ctrl_valid; // [RULE12]
	wire start_dac = idle && !adc_pend_q && !ctrl_valid &&
		dac_pend_q && fifo_out.valid; // [RULE1]
	wire start_any = start_read || start_ctrl || start_dac;

	assign ctrl_ready = start_ctrl;
	assign fifo_out.ready = start_dac;

	// Flags set by a request in the cycle they are taken stay set.
	assign dac_pend_d = dac_request || (dac_pend_q && !start_dac);
	assign adc_pend_d = adc_done || (adc_pend_q && !start_read);

	// Each space keeps its own count; the recommended mode forces the
	// figures that suit the converter pair.
	wire ws_t io_ws = use_recommended_ws ?
		`ADC_RECOMMENDED_WS : io_wait_states; // [RULE7] [RULE14]
	wire ws_t data_ws = use_recommended_ws ?
		`DAC_RECOMMENDED_WS : data_wait_states; // [RULE8] [RULE14]
	wire ws_t strobe_ws = (op_q == OP_DAC) ? data_ws : io_ws;

	wire cnt_done = (cnt_q == '0);
	wire ws_t cnt_dec = cnt_done ? cnt_q : cnt_q - 4'h1;
	wire op_is_write = (op_q != OP_READ);

	always_comb
	begin
		state_d = state_q;
		op_d = op_q;
		cnt_d = cnt_dec;
		case (state_q)
			ST_IDLE:
			begin
				if (start_any)
				begin
					state_d = ST_SETUP;
					op_d = start_read ? OP_READ :
						(start_ctrl ? OP_CTRL : OP_DAC);
					cnt_d = 4'(`SETUP_CYCLES - 1); // [RULE6]
				end
			end
			ST_SETUP:
			begin
				if (cnt_done)
				begin
					state_d = ST_STROBE;
					cnt_d = strobe_ws; // [RULE6] [RULE15]
				end
			end
			ST_STROBE:
			begin
				if (cnt_done)
				begin
					state_d = ST_HOLD;
					cnt_d = 4'(`HOLD_CYCLES - 1);
				end
			end
			ST_HOLD:
			begin
				if (cnt_done && op_is_write)
					state_d = ST_IDLE;
				else if (cnt_done)
				begin
					// The ADC may still drive the bus after a read.
					state_d = ST_TURN; // [RULE13]
					cnt_d = 4'(`TURN_CYCLES - 1);
				end
			end
			ST_TURN:
			begin
				if (cnt_done)
					state_d = ST_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
				op_d = OP_READ;
				cnt_d = '0;
			end
		endcase
	end

	// Pin values follow the next state so they leave flip-flops cleanly.
	wire active_d = (state_d == ST_SETUP) || (state_d == ST_STROBE) ||
		(state_d == ST_HOLD);
	wire strobe_d = (state_d == ST_STROBE);
	wire dss_n_d = !(active_d && op_d == OP_DAC); // [RULE2] [RULE15]
	wire ioss_n_d = !(active_d && op_d != OP_DAC); // [RULE2] [RULE15]
	// Strobes fall one setup period after the select, never with it.
	wire rd_n_d = !(strobe_d && op_d == OP_READ); // [RULE16]
	wire wr_n_d = !(strobe_d && op_d != OP_READ); // [RULE4]
	// Write data stands from the select edge through the hold period,
	// so it is valid across the whole strobe and after its rise.
	wire doe_d = active_d && op_d != OP_READ; // [RULE4] [RULE17]
	wire addr_t addr_d = start_dac ? DAC_ADDR : ADC_ADDR; // [RULE2]
	wire word_t dout_d = start_ctrl ? ctrl_data : fifo_out.data;
	// Data is taken at the edge where the read strobe rises.
	wire capture = (state_q == ST_STROBE) && cnt_done &&
		(op_q == OP_READ); // [RULE16]

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_IDLE;
			op_q <= OP_READ;
			cnt_q <= '0;
			dac_pend_q <= 1'b0;
			adc_pend_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			op_q <= op_d;
			cnt_q <= cnt_d;
			dac_pend_q <= dac_pend_d;
			adc_pend_q <= adc_pend_d;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dss_n_q <= 1'b1;
			ioss_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			doe_q <= 1'b0;
		end
		else
		begin
			dss_n_q <= dss_n_d;
			ioss_n_q <= ioss_n_d;
			rd_n_q <= rd_n_d;
			wr_n_q <= wr_n_d;
			doe_q <= doe_d;
		end
	end

	// Address and write data are loaded once per cycle and held, so
	// nothing on the bus moves during inserted wait states.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			addr_q <= '0;
			dout_q <= '0;
		end
		else if (start_any)
		begin
			addr_q <= addr_d; // [RULE15]
			dout_q <= dout_d; // [RULE4] [RULE12]
		end
	end

	// The bus value passes two synchroniser stages, so the word taken
	// is the one present two cycles before the rise; with the default
	// wait states the ADC data is stable long before that.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sample_data_q <= '0;
			sample_valid_q <= 1'b0;
		end
		else
		begin
			sample_valid_q <= capture;
			if (capture)
				sample_data_q <= din_s2_q; // [RULE16]
		end
	end

	assign addr = addr_q;
	assign data_space_select_n = dss_n_q;
	assign io_space_select_n = ioss_n_q;
	assign rd_n = rd_n_q;
	assign wr_n = wr_n_q;
	assign data_out = dout_q;
	assign data_oe = doe_q;
	assign sample_valid = sample_valid_q;
	assign sample_data = sample_data_q;
	assign bus_busy = !idle;

endmodule : pbus_master

// ---- bench/pbus_chk.sv ----
// Pin-level assertions for the parallel peripheral bus master.
// Assumes wait-state inputs change only while the bus is idle.
`timescale 1ns/1ns
module pbus_chk #(
	parameter pbus_pkg::addr_t ADC_ADDR = 14'h0000,
	parameter pbus_pkg::addr_t DAC_ADDR = 14'h0001
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Bus pins
	input wire pbus_pkg::addr_t addr,
	input wire logic data_space_select_n,
	input wire logic io_space_select_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire pbus_pkg::word_t data_out,
	input wire logic data_oe,
	// Configuration and status
	input wire logic use_recommended_ws,
	input wire pbus_pkg::ws_t io_wait_states,
	input wire pbus_pkg::ws_t data_wait_states,
	input wire logic sample_valid,
	input wire logic bus_busy
);
	import pbus_pkg::*;
	logic [4:0] wr_lo_q;
	logic [4:0] rd_lo_q;
	wire [3:0] rd_ws = use_recommended_ws ? 4'h5 : io_wait_states;
	// Control writes go to io space, so they use the io count.
	wire [3:0] wr_ws = data_space_select_n ? rd_ws :
		(use_recommended_ws ? 4'h2 : data_wait_states);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Low-time counters; the strobe width is judged on its rising edge.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_lo_q <= 5'h00;
			rd_lo_q <= 5'h00;
		end
		else
		begin
			wr_lo_q <= wr_n ? 5'h00 : wr_lo_q + 5'h01;
			rd_lo_q <= rd_n ? 5'h00 : rd_lo_q + 5'h01;
		end
	end
	sequence wr_starts;
		##1 $fell(wr_n);
	endsequence
	sequence strobe_starts;
		##1 ($fell(rd_n) || $fell(wr_n));
	endsequence
	sequence bus_quiet;
		!data_oe [*3];
	endsequence
	dac_order_a: assert property
		($fell(data_space_select_n) |-> wr_starts)
		else $error("write strobe did not follow data select");
	adc_order_a: assert property
		($fell(io_space_select_n) |-> strobe_starts)
		else $error("strobe did not follow io select");
	wr_width_a: assert property
		($rose(wr_n) |-> wr_lo_q == {1'b0, wr_ws} + 5'h01)
		else $error("write strobe width wrong");
	rd_width_a: assert property
		($rose(rd_n) |-> rd_lo_q == {1'b0, rd_ws} + 5'h01)
		else $error("read strobe width wrong");
	wait_stable_a: assert property
		(!wr_n |-> data_oe && $stable(data_out) && $stable(addr))
		else $error("write cycle moved during strobe");
	dac_addr_a: assert property
		(!data_space_select_n |-> addr == DAC_ADDR && io_space_select_n)
		else $error("data select with wrong address");
	adc_addr_a: assert property
		(!io_space_select_n |-> addr == ADC_ADDR)
		else $error("io select with wrong address");
	read_cap_a: assert property
		($rose(rd_n) |-> sample_valid && data_oe == 1'b0)
		else $error("no sample at read strobe rise");
	turn_gap_a: assert property
		($rose(rd_n) |-> bus_quiet)
		else $error("bus driven too soon after read");
	idle_free_a: assert property
		(!bus_busy |-> !data_oe && rd_n && wr_n)
		else $error("bus driven while idle");
endmodule : pbus_chk

// ---- bench/conv_model.sv ----
// Far-side model: parallel ADC and double-buffered DAC behind a decoder.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/1ns
module conv_model #(
	parameter pbus_pkg::addr_t ADC_ADDR = 14'h0000,
	parameter pbus_pkg::addr_t DAC_ADDR = 14'h0001
) (
	// Clock and bus pins
	input wire logic ref_clk,
	input wire pbus_pkg::addr_t addr,
	input wire logic data_space_select_n,
	input wire logic io_space_select_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire pbus_pkg::word_t data_out,
	input wire logic data_oe,
	output pbus_pkg::word_t data_in,
	// Request pins
	output logic adc_busy,
	output logic dac_latch_irq_n
);
	import pbus_pkg::*;
	word_t sample = 16'h0000;
	word_t junk = 16'h5A5A;
	word_t got_dac[$];
	word_t got_ctrl[$];
	wire adc_cs = !io_space_select_n && addr == ADC_ADDR;
	wire dac_cs = !data_space_select_n && addr == DAC_ADDR;
	// A released bus shows a pattern that changes every cycle.
	assign data_in = (adc_cs && !rd_n) ? sample : (data_oe ? data_out : junk);
	always @(posedge ref_clk)
		junk <= ~junk + 16'h0001;
	initial
	begin
		adc_busy = 1'b0;
		dac_latch_irq_n = 1'b1;
	end
	always @(posedge wr_n)
	begin
		if (dac_cs)
			got_dac.push_back(data_out);
		if (adc_cs)
			got_ctrl.push_back(data_out);
	end
	task automatic convert(input word_t val);
		sample = val;
		adc_busy = 1'b1;
		@(negedge ref_clk);
		adc_busy = 1'b0;
	endtask : convert
	task automatic latch_strobe();
		dac_latch_irq_n = 1'b0;
		@(negedge ref_clk);
		dac_latch_irq_n = 1'b1;
	endtask : latch_strobe
endmodule : conv_model

// ---- bench/pbus_master_tb.sv ----
// Self-checking bench for the parallel peripheral bus master.
// Assumes the far-side model answers on the converter pins and data bus.
`timescale 1ns/1ns
module pbus_master_tb;
	import pbus_pkg::*;
	localparam addr_t ADC_ADDR = 14'h0010;
	localparam addr_t DAC_ADDR = 14'h0021;
	logic ref_clk, arst_n, use_recommended_ws, dac_word_valid, ctrl_valid;
	logic data_space_select_n, io_space_select_n, rd_n, wr_n, data_oe;
	logic dac_word_ready, ctrl_ready, sample_valid, bus_busy;
	logic dac_latch_irq_n, adc_busy;
	addr_t addr;
	word_t data_out, data_in, dac_word_data, ctrl_data, sample_data, exp;
	ws_t io_wait_states, data_wait_states;
	word_t dac_q[$];
	logic [31:0] seed = 32'h0000_6935;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	int i;
	pbus_master #(.ADC_ADDR(ADC_ADDR), .DAC_ADDR(DAC_ADDR)) u_pbus_master (
		.ref_clk, .arst_n, .addr, .data_space_select_n, .io_space_select_n,
		.rd_n, .wr_n, .data_out, .data_oe, .data_in, .dac_latch_irq_n,
		.adc_busy, .use_recommended_ws, .io_wait_states, .data_wait_states,
		.dac_word_valid, .dac_word_data, .dac_word_ready, .ctrl_valid,
		.ctrl_data, .ctrl_ready, .sample_valid, .sample_data, .bus_busy);
	conv_model #(.ADC_ADDR(ADC_ADDR), .DAC_ADDR(DAC_ADDR)) u_conv_model (
		.ref_clk, .addr, .data_space_select_n, .io_space_select_n, .rd_n,
		.wr_n, .data_out, .data_oe, .data_in, .adc_busy, .dac_latch_irq_n);
	function automatic word_t rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd
	task automatic check(input word_t got, input word_t want);
		checks++;
		if (got !== want)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, want);
		end
	endtask : check
	task automatic finish_test();
		$display("n_errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	// Waits for an operation to start, then for the bus to go idle.
	task automatic op_wait(input logic want);
		int k;
		logic seen;
		seen = 1'b0;
		for (k = 0; k < 30 && !seen; k++)
		begin
			@(negedge ref_clk);
			seen = bus_busy;
		end
		check({15'h0000, seen}, {15'h0000, want});
		for (k = 0; k < 40 && bus_busy; k++)
			@(negedge ref_clk);
	endtask : op_wait
	task automatic dac_write(input ws_t ws, input logic rec);
		@(negedge ref_clk);
		use_recommended_ws = rec;
		data_wait_states = ws;
		u_conv_model.latch_strobe();
		op_wait(1'b1);
		check(u_conv_model.got_dac.pop_front(), dac_q.pop_front());
	endtask : dac_write
	initial
	begin
		ref_clk = 1'b0;
		forever
			#50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			finish_test();
		end
	end
	initial
	begin
		arst_n = 1'b0;
		use_recommended_ws = 1'b1;
		io_wait_states = 4'h0;
		data_wait_states = 4'h0;
		dac_word_valid = 1'b0;
		dac_word_data = 16'h0000;
		ctrl_valid = 1'b0;
		ctrl_data = 16'h0000;
		repeat (2) @(negedge ref_clk);
		arst_n = 1'b1;
		check({12'h000, rd_n, wr_n, data_oe, bus_busy}, 16'h000C);
		// Offer six words; the four-deep buffer must refuse the last two.
		for (i = 0; i < 6; i++)
		begin
			@(negedge ref_clk);
			dac_word_valid = 1'b1;
			// A refused word is held unchanged while the buffer is full.
			if (dac_word_ready === 1'b1)
			begin
				dac_word_data = rnd();
				dac_q.push_back(dac_word_data);
			end
		end
		@(negedge ref_clk);
		dac_word_valid = 1'b0;
		check(16'(dac_q.size()), 16'h0004);
		dac_write(4'h0, 1'b0);
		dac_write(4'hF, 1'b0);
		dac_write(4'h7, 1'b0);
		dac_write(4'h0, 1'b1);
		// An empty buffer must leave the request pending until a word comes.
		u_conv_model.latch_strobe();
		op_wait(1'b0);
		dac_word_valid = 1'b1;
		dac_word_data = rnd();
		dac_q.push_back(dac_word_data);
		@(negedge ref_clk);
		dac_word_valid = 1'b0;
		op_wait(1'b1);
		check(u_conv_model.got_dac.pop_front(), dac_q.pop_front());
		for (i = 0; i < 3; i++)
		begin
			use_recommended_ws = (i == 0);
			io_wait_states = (i == 1) ? 4'h2 : 4'hF;
			exp = rnd();
			u_conv_model.convert(exp);
			op_wait(1'b1);
			check(sample_data, exp);
		end
		// Control write queued behind a read must wait out the turnaround.
		exp = rnd();
		u_conv_model.convert(exp);
		for (i = 0; i < 30 && !bus_busy; i++)
			@(negedge ref_clk);
		ctrl_valid = 1'b1;
		ctrl_data = rnd();
		for (i = 0; i < 60 && ctrl_ready !== 1'b1; i++)
			@(negedge ref_clk);
		@(negedge ref_clk);
		ctrl_valid = 1'b0;
		op_wait(1'b1);
		check(sample_data, exp);
		check(u_conv_model.got_ctrl.pop_front(), ctrl_data);
		finish_test();
	end
endmodule : pbus_master_tb
bind pbus_master pbus_chk #(.ADC_ADDR(ADC_ADDR), .DAC_ADDR(DAC_ADDR))
	u_pbus_chk (
	.ref_clk, .arst_n, .addr, .data_space_select_n, .io_space_select_n,
	.rd_n, .wr_n, .data_out, .data_oe, .use_recommended_ws,
	.io_wait_states, .data_wait_states, .sample_valid, .bus_busy);
